// ---- rtl/cbrs_lock_if.sv ----
// Interface: lock request and status between capture and lock tracker.
`timescale 1ns/1ps
interface cbrs_lock_if;
    logic start;
    logic locked;
    modport ctrl (output start, input locked);
    modport pll (input start, output locked);
endinterface

// ---- rtl/cbrs_lock_tracker.sv ----
// Module: lock-time tracker that models the multiplier settling.
`timescale 1ns/1ps
module cbrs_lock_tracker
    import cbrs_pkg::*;
(
    // Clock and reset.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Lock handshake.
    cbrs_lock_if.pll lk
);
    logic [LOCK_CNT_W-1:0] cnt;
    logic locked;

    assign lk.locked = locked;

    // Restarts on every start so a fresh reset always relocks.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt <= '0;
            locked <= 1'b0;
        end else if (i_ce) begin
            if (lk.start) begin
                cnt <= '0;
                locked <= 1'b0;
            end else if (!locked) begin
                if (cnt == LOCK_CNT_W'(LOCK_CYCLES - 1)) begin
                    locked <= 1'b1;
                end else begin
                    cnt <= cnt + 1'b1;
                end
            end
        end
    end

    property p_lock_time;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        $fell(locked) |-> !locked [*8];
    endproperty
    a_lock_time: assert property (p_lock_time)
        else $error("lock rose too soon after restart");
endmodule

// ---- rtl/cbrs_pkg.sv ----
// Package: constants and types for the core/bus ratio strap capture block.
package cbrs_pkg;

    // Strap vector order: {local_irq1, local_irq0, ignore_numeric_error,
    // addr_bit20_mask}.
    localparam int STRAP_W = 4;
    localparam int EBL_W = 5;

    // Decoded ratio codes as seen in the power-up register field.
    localparam logic [EBL_W-1:0] EBL_SAFE_LLLL = 5'h03;
    localparam logic [EBL_W-1:0] EBL_R7 = 5'h09;
    localparam logic [EBL_W-1:0] EBL_R9 = 5'h10;
    localparam logic [EBL_W-1:0] EBL_SAFE_HHHH = 5'h0c;
    localparam logic [EBL_W-1:0] EBL_RESET = 5'h03;

    // Strap patterns.
    localparam logic [STRAP_W-1:0] STRAP_LLLL = 4'h0;
    localparam logic [STRAP_W-1:0] STRAP_HLHL = 4'ha;
    localparam logic [STRAP_W-1:0] STRAP_HHHH = 4'hf;

    // Core multiplier values.
    localparam logic [3:0] MULT_SAFE = 4'h4;
    localparam logic [3:0] MULT_7 = 4'h7;
    localparam logic [3:0] MULT_9 = 4'h9;
    localparam logic [3:0] MULT_RESET = 4'h4;

    // Phase-lock settle time and its count at 100 MHz.
    localparam int CLK_MHZ = 100;
    localparam int LOCK_TIME_US = 10;
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
    localparam int LOCK_CNT_W = 11;

    typedef enum logic [2:0] {
        CBRS_IDLE = 3'b001,
        CBRS_SAMPLE = 3'b010,
        CBRS_RUN = 3'b100
    } cbrs_state_e;

endpackage

// ---- rtl/cbrs_strap_capture.sv ----
// Module: core/bus ratio strap sampling, latching and ratio decode.
`timescale 1ns/1ps
module cbrs_strap_capture
    import cbrs_pkg::*;
(
    // Clock, reset and enable.
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    input wire logic i_ce,
    // Device reset pin, active low, synchronous to the bus clock.
    input wire logic i_dev_reset_n,
    // Speed grade strap: high selects the fixed 9:1 grade.
    input wire logic i_fixed_grade,
    // Shared ratio pins.
    input wire logic i_addr_bit20_mask_pin,
    input wire logic i_ignore_numeric_error_pin,
    input wire logic i_local_irq0_pin,
    input wire logic i_local_irq1_pin,
    // Ratio results.
    output logic [3:0] o_core_mult,
    output logic [cbrs_pkg::EBL_W-1:0] o_ratio_code,
    output logic o_ratio_valid,
    output logic o_ratio_unsupported,
    output logic o_pins_functional,
    output logic o_pll_locked
);
    import cbrs_pkg::*;

    cbrs_state_e state;
    cbrs_state_e next_state;
    logic [STRAP_W-1:0] pins;
    logic [STRAP_W-1:0] sampled;
    logic reset_d;
    logic fixed_grade;
    cbrs_lock_if lk ();

    assign pins = {i_local_irq1_pin, i_local_irq0_pin,
                   i_ignore_numeric_error_pin, i_addr_bit20_mask_pin};

    function automatic logic [3:0] decode_mult(input logic fixed,
                                               input logic [3:0] s);
        if (fixed) begin
            decode_mult = MULT_9;
        end else if (s == STRAP_HLHL) begin
            decode_mult = MULT_7;
        end else begin
            decode_mult = MULT_SAFE;
        end
    endfunction

    function automatic logic [EBL_W-1:0] decode_code(input logic fixed,
                                                     input logic [3:0] s);
        if (fixed) begin
            decode_code = EBL_R9;
        end else if (s == STRAP_HLHL) begin
            decode_code = EBL_R7;
        end else if (s == STRAP_HHHH) begin
            decode_code = EBL_SAFE_HHHH;
        end else begin
            decode_code = EBL_SAFE_LLLL;
        end
    endfunction

    // Outside the fixed grade, unlisted patterns fall back to the safe ratio but are flagged.
    function automatic logic is_unsupported(input logic fixed,
                                            input logic [3:0] s);
        is_unsupported = !fixed && (s != STRAP_LLLL) &&
                         (s != STRAP_HHHH) && (s != STRAP_HLHL);
    endfunction

    cbrs_lock_tracker u_lock (
        .i_sys_clk(i_sys_clk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .lk(lk.pll)
    );

    // Lock restarts on the inactive-to-active edge of the reset pin.
    assign lk.start = reset_d && !i_dev_reset_n;
    assign o_pll_locked = lk.locked;

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            reset_d <= 1'b1;
        end else if (i_ce) begin
            reset_d <= i_dev_reset_n;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            CBRS_IDLE: begin
                if (!i_dev_reset_n) begin
                    next_state = CBRS_SAMPLE;
                end
            end
            CBRS_SAMPLE: begin
                if (i_dev_reset_n) begin
                    next_state = CBRS_RUN;
                end
            end
            CBRS_RUN: begin
                if (!i_dev_reset_n) begin
                    next_state = CBRS_SAMPLE;
                end
            end
            default: next_state = CBRS_IDLE;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= CBRS_IDLE;
        end else if (i_ce) begin
            state <= next_state;
        end
    end

    // Track the straps every cycle of reset so the last level before
    // release wins; the long setup keeps that level settled.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sampled <= STRAP_LLLL;
            fixed_grade <= 1'b0;
        end else if (i_ce && !i_dev_reset_n) begin
            sampled <= pins;
            fixed_grade <= i_fixed_grade;
        end
    end

    // Ratio fields update only on release and then hold, while valid and
    // functional clear during reset; pin traffic after release cannot disturb them.
    always_ff @(posedge i_sys_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_core_mult <= MULT_RESET;
            o_ratio_code <= EBL_RESET;
            o_ratio_valid <= 1'b0;
            o_ratio_unsupported <= 1'b0;
            o_pins_functional <= 1'b0;
        end else if (i_ce) begin
            if (!i_dev_reset_n) begin
                o_ratio_valid <= 1'b0;
                o_pins_functional <= 1'b0;
            end else if (state == CBRS_SAMPLE) begin
                o_core_mult <= decode_mult(fixed_grade, sampled);
                o_ratio_code <= decode_code(fixed_grade, sampled);
                o_ratio_unsupported <= is_unsupported(fixed_grade,
                                                      sampled);
                o_ratio_valid <= 1'b1;
                o_pins_functional <= 1'b1;
            end
        end
    end

    property p_hold_latched;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (o_ratio_valid && i_dev_reset_n && $past(o_ratio_valid))
        |-> $stable(o_core_mult) && $stable(o_ratio_code);
    endproperty
    a_hold_latched: assert property (p_hold_latched)
        else $error("latched ratio changed while out of reset");

    property p_fixed_nine;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_ce && state == CBRS_SAMPLE && i_dev_reset_n && fixed_grade)
        |=> o_core_mult == MULT_9;
    endproperty
    a_fixed_nine: assert property (p_fixed_nine)
        else $error("fixed grade did not run at nine");

    property p_seven;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_ce && state == CBRS_SAMPLE && i_dev_reset_n && !fixed_grade
         && sampled == STRAP_HLHL)
        |=> o_core_mult == MULT_7 && o_ratio_code == EBL_R7;
    endproperty
    a_seven: assert property (p_seven)
        else $error("HLHL straps did not give seven");

    property p_safe;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_ce && state == CBRS_SAMPLE && i_dev_reset_n && !fixed_grade
         && (sampled == STRAP_LLLL || sampled == STRAP_HHHH))
        |=> o_core_mult == MULT_SAFE;
    endproperty
    a_safe: assert property (p_safe)
        else $error("safe straps did not give four");

    property p_sample;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_ce && !i_dev_reset_n) |=> sampled == $past(pins);
    endproperty
    a_sample: assert property (p_sample)
        else $error("straps not sampled during reset");

    property p_release;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_ce && state == CBRS_SAMPLE && i_dev_reset_n)
        |=> o_ratio_valid && o_pins_functional;
    endproperty
    a_release: assert property (p_release)
        else $error("ratio not latched at release");

    property p_lock_start;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_ce && reset_d && !i_dev_reset_n) |=> !lk.locked;
    endproperty
    a_lock_start: assert property (p_lock_start)
        else $error("lock did not restart on reset");

    property p_reset_clears;
        @(posedge i_sys_clk) disable iff (!i_rstn)
        (i_ce && !i_dev_reset_n) |=> !o_ratio_valid && !o_pins_functional;
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("ratio still valid during reset");
endmodule

// ---- verification/cbrs_sys_model.sv ----
// Partner model: system reset logic and strap multiplexer on shared pins.
`timescale 1ns/1ps
module cbrs_sys_model #(
    parameter int SETUP_CYC = 20,
    parameter int HOLD_CYC = 5
) (
    // Clock.
    input wire logic i_sys_clk,
    // Device reset and shared pins, {irq1, irq0, ignore_numeric_error_pin, a20}.
    output logic o_dev_reset_n,
    output logic [3:0] o_pins
);
    // Pull-ups hold the safe all-high pattern until the mux drives.
    initial begin
        o_dev_reset_n = 1'b1;
        o_pins = 4'hf;
    end
    // The true setup is 1 ms; a short count keeps the run small.
    task automatic enter(input logic [3:0] strap);
        @(posedge i_sys_clk);
        #1;
        o_dev_reset_n = 1'b0;
        o_pins = strap;
        repeat (SETUP_CYC) @(posedge i_sys_clk);
        #2;
    endtask
    task automatic leave();
        @(posedge i_sys_clk);
        #1;
        o_dev_reset_n = 1'b1;
        repeat (HOLD_CYC) @(posedge i_sys_clk);
        #2;
    endtask
    // Normal signalling changes every cycle, so a stale latch would show.
    task automatic traffic(input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_sys_clk);
            #1;
            o_pins = ~o_pins;
        end
        @(posedge i_sys_clk);
        #2;
    endtask
endmodule

// ---- verification/core_bus_ratio_strap_capture_tb_top.sv ----
// Testbench: boots the strap capture block through each ratio setting.
`timescale 1ns/1ps
module core_bus_ratio_strap_capture_tb_top;
    import cbrs_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic fixed_grade = 1'b0;
    logic dev_reset_n;
    logic [3:0] pins;
    logic [3:0] core_mult;
    logic [EBL_W-1:0] ratio_code;
    logic ratio_valid, ratio_unsupported, pins_functional, pll_locked;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    logic case_grade [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [3:0] case_strap [6] = '{STRAP_LLLL, STRAP_HLHL, STRAP_HHHH,
        STRAP_HLHL, STRAP_LLLL, 4'h5};
    logic [3:0] case_mult [6] = '{MULT_SAFE, MULT_7, MULT_SAFE, MULT_9,
        MULT_9, MULT_SAFE};
    logic [EBL_W-1:0] case_code [6] = '{EBL_SAFE_LLLL, EBL_R7,
        EBL_SAFE_HHHH, EBL_R9, EBL_R9, EBL_RESET};
    logic case_unsup [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

    // The bus clock never changes rate.
    always #5 sys_clk = ~sys_clk;

    cbrs_sys_model sys_u (
        .i_sys_clk(sys_clk),
        .o_dev_reset_n(dev_reset_n),
        .o_pins(pins)
    );

    cbrs_strap_capture dut_u (
        .i_sys_clk(sys_clk),
        .i_rstn(rstn),
        .i_ce(ce),
        .i_dev_reset_n(dev_reset_n),
        .i_fixed_grade(fixed_grade),
        .i_addr_bit20_mask_pin(pins[0]),
        .i_ignore_numeric_error_pin(pins[1]),
        .i_local_irq0_pin(pins[2]),
        .i_local_irq1_pin(pins[3]),
        .o_core_mult(core_mult),
        .o_ratio_code(ratio_code),
        .o_ratio_valid(ratio_valid),
        .o_ratio_unsupported(ratio_unsupported),
        .o_pins_functional(pins_functional),
        .o_pll_locked(pll_locked)
    );

    task automatic results();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask

    // Unlisted patterns have no defined code, so the code check is skipped; multiplier and flag are still judged.
    task automatic check_ratio(input int i);
        chk(core_mult === case_mult[i] && ratio_valid === 1'b1 &&
            pins_functional === 1'b1 &&
            ratio_unsupported === case_unsup[i], "ratio outputs");
        if (!case_unsup[i]) begin
            chk(ratio_code === case_code[i], "ratio code");
        end
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            $display("unexpected at %0t: timeout", $time);
            results();
        end
    end

    initial begin
        repeat (5) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            #1;
            fixed_grade = case_grade[i];
            sys_u.enter(case_strap[i]);
            chk(ratio_valid === 1'b0 && pins_functional === 1'b0,
                "outputs during reset");
            sys_u.leave();
            check_ratio(i);
            if (i == 0) begin
                chk(pll_locked === 1'b0, "lock too early");
            end
            // Pins go back to normal use after the hold window.
            sys_u.traffic(8);
            check_ratio(i);
            if (i == 0) begin
                repeat (LOCK_CYCLES) @(posedge sys_clk);
                #2;
                chk(pll_locked === 1'b1, "lock missing");
            end
        end
        // A low clock enable across release must delay the latch.
        sys_u.enter(STRAP_HLHL);
        @(posedge sys_clk);
        #1;
        ce = 1'b0;
        sys_u.leave();
        chk(ratio_valid === 1'b0, "latched while enable low");
        chk(core_mult === MULT_SAFE, "ratio moved while frozen");
        @(posedge sys_clk);
        #1;
        ce = 1'b1;
        @(posedge sys_clk);
        #2;
        check_ratio(1);
        // A system reset in mid-run returns every output to its idle value.
        @(posedge sys_clk);
        #1;
        rstn = 1'b0;
        @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        @(posedge sys_clk);
        #2;
        chk(core_mult === MULT_RESET && ratio_code === EBL_RESET &&
            ratio_valid === 1'b0 && pins_functional === 1'b0,
            "outputs after system reset");
        chk(pll_locked === 1'b0, "lock survived system reset");
        sys_u.enter(STRAP_HHHH);
        sys_u.leave();
        check_ratio(2);
        results();
    end
endmodule
